// [src/supervisory_link_register_map.v]
// Holding register map and link supervision behind the supervisory port
`include "supervisory_link_defines.vh"

module supervisory_link_register_map #(
  parameter TW = 32
) (
  // Clock and reset
  input  wire          clk,
  input  wire          rst_n,
  input  wire          ce,
  // Holding register port
  input  wire          regRd,
  input  wire          regWr,
  input  wire [15:0]   regAddr,
  input  wire [15:0]   regWrData,
  output reg  [15:0]   regRdData_r,
  output reg           regAck_r,
  output reg           regExc_r,
  output reg  [7:0]    excCode_r,
  // Device configuration and status
  input  wire [TW-1:0] linkAliveTimeout,
  input  wire [8:0]    acceptMask,
  input  wire [31:0]   burnerCycles,
  input  wire [31:0]   burnerHours,
  input  wire [15:0]   firingRateIn,
  input  wire [2:0]    errorTypeIn,
  input  wire [15:0]   relayMapIn,
  // Values for the boiler sequencer
  output wire          linkLost,
  output reg           spaceHeatPermit_r,
  output reg           spaceHeatDemand_r,
  output reg  [15:0]   spaceHeatSetpoint_r,
  output reg           hotWaterPermit_r,
  output reg           hotWaterDemand_r,
  output reg  [15:0]   hotWaterSetpoint_r,
  output reg  [15:0]   tankSetpoint_r,
  output reg  [15:0]   headerTemp_r,
  output reg  [15:0]   outdoorTemp_r,
  output reg  [15:0]   loopCurrent_r,
  output reg  [15:0]   hotWaterTemp_r
);

  // ****************************************
  // Functions
  // ****************************************
  function inSignedRange;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      inSignedRange = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
    end
  endfunction

  // Slot of a remote value register, 3'h7 if none
  function [2:0] slotOf;
    input [15:0] a;
    begin
      case (a)
        `ADDR_HEADER_TEMP:  slotOf = 3'h0;
        `ADDR_OUTDOOR_TEMP: slotOf = 3'h1;
        `ADDR_LOOP_CURRENT: slotOf = 3'h2;
        `ADDR_HW_TEMP:      slotOf = 3'h3;
        default:            slotOf = 3'h7;
      endcase
    end
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  reg  [15:0] aliveWord_r;
  reg  [15:0] shEnable_r;
  reg  [15:0] shSetpoint_r;
  reg  [15:0] shDemand_r;
  reg  [15:0] hwEnable_r;
  reg  [15:0] hwSetpoint_r;
  reg  [15:0] tankSp_r;
  reg  [15:0] hwDemand_r;
  reg  [15:0] valRaw_r [0:3];
  reg  [3:0]  valSet_r;
  reg  [15:0] cycleLoSnap_r;
  reg  [15:0] hoursLoSnap_r;
  wire        lostEvent;
  wire [2:0]  wrSlot;
  wire        isCtrl;
  wire        ctrlValid;
  wire        rangeOk;
  reg  [15:0] shown [0:3];
  reg  [15:0] rdMux;
  reg         rdHit;
  reg         wrHit;
  integer     i;

  link_alive_monitor #(
    .TW (TW)
  ) uMonitor (
    .clk         (clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .wordWr      (regWr && (regAddr == `ADDR_LINK_ALIVE)),
    .wordData    (regWrData),
    .timeout     (linkAliveTimeout),
    .linkLost_r  (linkLost),
    .lostEvent_r (lostEvent)
  );

  assign wrSlot    = slotOf(regAddr);
  assign isCtrl    = (regAddr == `ADDR_SH_ENABLE) || (regAddr == `ADDR_SH_DEMAND) ||
                     (regAddr == `ADDR_HW_ENABLE) || (regAddr == `ADDR_HW_DEMAND);
  assign ctrlValid = (regWrData == `CTRL_OFF) || (regWrData == `CTRL_ON);
  assign rangeOk   = (wrSlot == 3'h2) ? ((regWrData >= `LOOP_MIN) && (regWrData <= `LOOP_MAX))
                   : inSignedRange(regWrData, `TEMP_MIN, `TEMP_MAX);

  // ****************************************
  // Shown value of remote inputs
  // ****************************************
  always @*
  begin
    for (i = 0; i < 4; i = i + 1)
      shown[i] = (linkLost || !valSet_r[i]) ? `CODE_OPEN : valRaw_r[i];
  end

  // ****************************************
  // Write decode
  // ****************************************
  always @*
  begin
    case (regAddr)
      `ADDR_LINK_ALIVE, `ADDR_SH_ENABLE, `ADDR_SH_SETPOINT, `ADDR_SH_DEMAND,
      `ADDR_HEADER_TEMP, `ADDR_OUTDOOR_TEMP, `ADDR_LOOP_CURRENT,
      `ADDR_HW_ENABLE, `ADDR_HW_SETPOINT, `ADDR_TANK_SETPOINT,
      `ADDR_HW_DEMAND, `ADDR_HW_TEMP: wrHit = 1'b1;
      default:                        wrHit = 1'b0;
    endcase
  end

  // ****************************************
  // Read mux
  // ****************************************
  always @*
  begin
    rdHit = 1'b1;
    case (regAddr)
      `ADDR_RELAY_MAP:     rdMux = relayMapIn;
      `ADDR_FIRING_RATE:   rdMux = (firingRateIn > `FIRING_MAX) ? `FIRING_MAX : firingRateIn;
      `ADDR_ERROR_TYPE:    rdMux = ({13'h0000, errorTypeIn} > `ERROR_TYPE_MAX) ?
                                   `ERROR_TYPE_MAX : {13'h0000, errorTypeIn};
      `ADDR_CYCLE_HI:      rdMux = burnerCycles[31:16];
      `ADDR_CYCLE_LO:      rdMux = cycleLoSnap_r;
      `ADDR_HOURS_HI:      rdMux = burnerHours[31:16];
      `ADDR_HOURS_LO:      rdMux = hoursLoSnap_r;
      `ADDR_LINK_ALIVE:    rdMux = aliveWord_r;
      `ADDR_SH_ENABLE:     rdMux = shEnable_r;
      `ADDR_SH_SETPOINT:   rdMux = shSetpoint_r;
      `ADDR_SH_DEMAND:     rdMux = shDemand_r;
      `ADDR_HEADER_TEMP:   rdMux = shown[0];
      `ADDR_OUTDOOR_TEMP:  rdMux = shown[1];
      `ADDR_LOOP_CURRENT:  rdMux = shown[2];
      `ADDR_HW_ENABLE:     rdMux = hwEnable_r;
      `ADDR_HW_SETPOINT:   rdMux = hwSetpoint_r;
      `ADDR_TANK_SETPOINT: rdMux = tankSp_r;
      `ADDR_HW_DEMAND:     rdMux = hwDemand_r;
      `ADDR_HW_TEMP:       rdMux = shown[3];
      default:
      begin
        rdMux = 16'h0000;
        rdHit = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Register file and bus answer
  // ****************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aliveWord_r   <= 16'h0000;
      shEnable_r    <= `CTRL_RESET;
      shSetpoint_r  <= `SETPOINT_INACTIVE;
      shDemand_r    <= `CTRL_OFF;
      hwEnable_r    <= `CTRL_RESET;
      hwSetpoint_r  <= `SETPOINT_INACTIVE;
      tankSp_r      <= `SETPOINT_INACTIVE;
      hwDemand_r    <= `CTRL_OFF;
      valRaw_r[0]   <= `CODE_OPEN;
      valRaw_r[1]   <= `CODE_OPEN;
      valRaw_r[2]   <= `CODE_OPEN;
      valRaw_r[3]   <= `CODE_OPEN;
      valSet_r      <= 4'h0;
      cycleLoSnap_r <= 16'h0000;
      hoursLoSnap_r <= 16'h0000;
      regRdData_r   <= 16'h0000;
      regAck_r      <= 1'b0;
      regExc_r      <= 1'b0;
      excCode_r     <= 8'h00;
    end
    else if (ce)
    begin
      regAck_r <= 1'b0;
      regExc_r <= 1'b0;
      if (lostEvent)
      begin
        valRaw_r[0] <= `CODE_OPEN;
        valRaw_r[1] <= `CODE_OPEN;
        valRaw_r[2] <= `CODE_OPEN;
        valRaw_r[3] <= `CODE_OPEN;
        valSet_r <= 4'h0;
      end
      if (regWr)
      begin
        if (!wrHit)
        begin
          regExc_r  <= 1'b1;
          excCode_r <= `EXC_ILLEGAL_ADDR;
        end
        else if (isCtrl && !ctrlValid)
        begin
          regExc_r  <= 1'b1;
          excCode_r <= `EXC_ILLEGAL_VALUE;
        end
        else
        begin
          regAck_r <= 1'b1;
          case (regAddr)
            `ADDR_LINK_ALIVE:    aliveWord_r  <= regWrData;
            `ADDR_SH_ENABLE:     shEnable_r   <= regWrData;
            `ADDR_SH_SETPOINT:   shSetpoint_r <= regWrData;
            `ADDR_SH_DEMAND:     shDemand_r   <= regWrData;
            `ADDR_HW_ENABLE:     hwEnable_r   <= regWrData;
            `ADDR_HW_SETPOINT:   hwSetpoint_r <= regWrData;
            `ADDR_TANK_SETPOINT: tankSp_r     <= regWrData;
            `ADDR_HW_DEMAND:     hwDemand_r   <= regWrData;
            default:
            begin
              valRaw_r[wrSlot[1:0]] <= rangeOk ? regWrData : `CODE_UNRELIABLE;
              valSet_r[wrSlot[1:0]] <= 1'b1;
            end
          endcase
        end
      end
      else if (regRd)
      begin
        if (rdHit)
        begin
          regAck_r    <= 1'b1;
          regRdData_r <= rdMux;
          if (regAddr == `ADDR_CYCLE_HI)
            cycleLoSnap_r <= burnerCycles[15:0];
          if (regAddr == `ADDR_HOURS_HI)
            hoursLoSnap_r <= burnerHours[15:0];
        end
        else
        begin
          regExc_r  <= 1'b1;
          excCode_r <= `EXC_ILLEGAL_ADDR;
        end
      end
    end
  end

  // ****************************************
  // Values handed to the sequencer
  // ****************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spaceHeatPermit_r   <= 1'b0;
      spaceHeatDemand_r   <= 1'b0;
      spaceHeatSetpoint_r <= `SETPOINT_INACTIVE;
      hotWaterPermit_r    <= 1'b0;
      hotWaterDemand_r    <= 1'b0;
      hotWaterSetpoint_r  <= `SETPOINT_INACTIVE;
      tankSetpoint_r      <= `SETPOINT_INACTIVE;
      headerTemp_r        <= `CODE_OPEN;
      outdoorTemp_r       <= `CODE_OPEN;
      loopCurrent_r       <= `CODE_OPEN;
      hotWaterTemp_r      <= `CODE_OPEN;
    end
    else if (ce)
    begin
      spaceHeatPermit_r   <= shEnable_r[0];
      spaceHeatDemand_r   <= shEnable_r[0] && acceptMask[`ACC_SH_DEMAND] && shDemand_r[0];
      spaceHeatSetpoint_r <= acceptMask[`ACC_SH_SETPOINT] ? shSetpoint_r : `SETPOINT_INACTIVE;
      hotWaterPermit_r    <= hwEnable_r[0];
      hotWaterDemand_r    <= hwEnable_r[0] && acceptMask[`ACC_HW_DEMAND] && hwDemand_r[0];
      hotWaterSetpoint_r  <= acceptMask[`ACC_HW_SETPOINT] ? hwSetpoint_r : `SETPOINT_INACTIVE;
      tankSetpoint_r      <= acceptMask[`ACC_TANK_SETPOINT] ? tankSp_r : `SETPOINT_INACTIVE;
      headerTemp_r        <= acceptMask[`ACC_HEADER_TEMP] ? shown[0] : `CODE_OPEN;
      outdoorTemp_r       <= acceptMask[`ACC_OUTDOOR_TEMP] ? shown[1] : `CODE_OPEN;
      loopCurrent_r       <= acceptMask[`ACC_LOOP_CURRENT] ? shown[2] : `CODE_OPEN;
      hotWaterTemp_r      <= acceptMask[`ACC_HW_TEMP] ? shown[3] : `CODE_OPEN;
    end
  end

endmodule // supervisory_link_register_map

// [common/supervisory_link_defines.vh]
// Constants for the supervisory link register map
`ifndef SUPERVISORY_LINK_DEFINES_VH
`define SUPERVISORY_LINK_DEFINES_VH

// ****************************************
// Holding register addresses
// ****************************************
`define ADDR_RELAY_MAP      16'h006F
`define ADDR_FIRING_RATE    16'h0087
`define ADDR_ERROR_TYPE     16'h008A
`define ADDR_CYCLE_HI       16'h0097
`define ADDR_CYCLE_LO       16'h0098
`define ADDR_HOURS_HI       16'h0099
`define ADDR_HOURS_LO       16'h009A
`define ADDR_LINK_ALIVE     16'h00AA
`define ADDR_SH_ENABLE      16'h00AB
`define ADDR_SH_SETPOINT    16'h00AC
`define ADDR_SH_DEMAND      16'h00AD
`define ADDR_HEADER_TEMP    16'h00AE
`define ADDR_OUTDOOR_TEMP   16'h00AF
`define ADDR_LOOP_CURRENT   16'h00B0
`define ADDR_HW_ENABLE      16'h00BF
`define ADDR_HW_SETPOINT    16'h00C0
`define ADDR_TANK_SETPOINT  16'h00C1
`define ADDR_HW_DEMAND      16'h00C2
`define ADDR_HW_TEMP        16'h00C3

// ****************************************
// Link alive words
// ****************************************
`define ALIVE_WORD_A        16'hABCD
`define ALIVE_WORD_B        16'hDCBA

// ****************************************
// Fault codes, ranges and control values
// ****************************************
`define CODE_SHORT          16'h8000
`define CODE_OPEN           16'h8100
`define CODE_HIGH           16'h8300
`define CODE_LOW            16'h8400
`define CODE_UNRELIABLE     16'h8500
`define SETPOINT_INACTIVE   16'h8300
`define TEMP_MIN            16'hFE70
`define TEMP_MAX            16'h0514
`define LOOP_MIN            16'h0028
`define LOOP_MAX            16'h00C8
`define FIRING_MAX          16'h00C8
`define ERROR_TYPE_MAX      16'h0004
`define CTRL_OFF            16'h0000
`define CTRL_ON             16'h0001
`define CTRL_RESET          16'h0001

// ****************************************
// Exception codes
// ****************************************
`define EXC_ILLEGAL_ADDR    8'h02
`define EXC_ILLEGAL_VALUE   8'h03

// ****************************************
// Acceptance mask bit positions
// ****************************************
`define ACC_SH_SETPOINT     0
`define ACC_SH_DEMAND       1
`define ACC_HEADER_TEMP     2
`define ACC_OUTDOOR_TEMP    3
`define ACC_LOOP_CURRENT    4
`define ACC_HW_SETPOINT     5
`define ACC_TANK_SETPOINT   6
`define ACC_HW_DEMAND       7
`define ACC_HW_TEMP         8

`endif

// [src/link_alive_monitor.v]
// Watchdog on the alternating link alive word
`include "supervisory_link_defines.vh"

module link_alive_monitor #(
  parameter TW = 32
) (
  // Clock and reset
  input  wire          clk,
  input  wire          rst_n,
  input  wire          ce,
  // Word writes
  input  wire          wordWr,
  input  wire [15:0]   wordData,
  input  wire [TW-1:0] timeout,
  // Status
  output reg           linkLost_r,
  output reg           lostEvent_r
);

  reg  [15:0]   lastWord_r;
  reg  [TW-1:0] timer_r;
  wire          validWord;
  wire          alternated;

  assign validWord  = (wordData == `ALIVE_WORD_A) || (wordData == `ALIVE_WORD_B);
  assign alternated = wordWr && validWord && (wordData != lastWord_r);

  // ****************************************
  // Timer and lost flag
  // ****************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lastWord_r  <= 16'h0000;
      timer_r     <= {TW{1'b0}};
      linkLost_r  <= 1'b1;
      lostEvent_r <= 1'b0;
    end
    else if (ce)
    begin
      lostEvent_r <= 1'b0;
      if (alternated)
      begin
        lastWord_r <= wordData;
        timer_r    <= {TW{1'b0}};
        linkLost_r <= 1'b0;
      end
      else if (!linkLost_r)
      begin
        if (timer_r >= timeout)
        begin
          linkLost_r  <= 1'b1;
          lostEvent_r <= 1'b1;
        end
        else
          timer_r <= timer_r + {{(TW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // link_alive_monitor

// [test/supervisory_link_register_map_chk.sv]
// Port checker for the supervisory link register map
module supervisory_link_register_map_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  // Register port
  input wire logic        regRd,
  input wire logic        regWr,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regAck_r,
  input wire logic        regExc_r,
  input wire logic [7:0]  excCode_r,
  // Sequencer side
  input wire logic [8:0]  acceptMask,
  input wire logic        linkLost,
  input wire logic        spaceHeatPermit_r,
  input wire logic        spaceHeatDemand_r,
  input wire logic [15:0] spaceHeatSetpoint_r,
  input wire logic [15:0] headerTemp_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire req = ce && (regRd || regWr);
  wire wrCtl = req && regWr && regAddr == 16'h00AB;
  property p_answer; req |=> regAck_r != regExc_r; endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_quiet; ce && !regRd && !regWr |=> !regAck_r && !regExc_r; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_hold; !ce |=> $stable(regAck_r) && $stable(regExc_r) &&
    $stable(linkLost) && $stable(headerTemp_r); endproperty
  a_hold: assert property (p_hold) else $error("state moved while clock enable low");
  property p_ro; req && regWr && regAddr == 16'h0097 |=> regExc_r && excCode_r == 8'h02; endproperty
  a_ro: assert property (p_ro) else $error("read-only write not refused");
  property p_ctrl; wrCtl && regWrData > 16'h0001 |=> regExc_r && excCode_r == 8'h03; endproperty
  a_ctrl: assert property (p_ctrl) else $error("bad control value not refused");
  property p_off; wrCtl && regWrData == 16'h0000 |-> ##2 !spaceHeatPermit_r; endproperty
  a_off: assert property (p_off) else $error("service not disabled");
  property p_demand; spaceHeatDemand_r |-> spaceHeatPermit_r && $past(acceptMask[1]); endproperty
  a_demand: assert property (p_demand) else $error("demand without permit");
  property p_setpt; !$past(acceptMask[0]) |-> spaceHeatSetpoint_r == 16'h8300; endproperty
  a_setpt: assert property (p_setpt) else $error("setpoint used while not accepted");
  property p_lost; linkLost [*4] |-> headerTemp_r == 16'h8100; endproperty
  a_lost: assert property (p_lost) else $error("value kept while link lost");
endmodule // supervisory_link_register_map_chk

bind supervisory_link_register_map supervisory_link_register_map_chk i_chk (
  .clk(clk), .rst_n(rst_n), .ce(ce), .regRd(regRd), .regWr(regWr), .regAddr(regAddr),
  .regWrData(regWrData), .regAck_r(regAck_r), .regExc_r(regExc_r), .excCode_r(excCode_r),
  .acceptMask(acceptMask), .linkLost(linkLost), .spaceHeatPermit_r(spaceHeatPermit_r),
  .spaceHeatDemand_r(spaceHeatDemand_r), .spaceHeatSetpoint_r(spaceHeatSetpoint_r),
  .headerTemp_r(headerTemp_r));

// [test/supervisory_master_model.sv]
// Supervisory master issuing holding register requests
module supervisory_master_model (
  // Clock
  input wire logic    clk,
  // Request
  output logic        regRd,
  output logic        regWr,
  output logic [15:0] regAddr,
  output logic [15:0] regWrData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic aliveSel = 1'b0;
  initial
  begin
    regRd = 1'b0;
    regWr = 1'b0;
    regAddr = 16'h0000;
    regWrData = 16'h0000;
  end
  // One-cycle request; answer is settled on return
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= w;
    regRd <= ~w;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
    #1;
  endtask
  task automatic beat();
    xfer(1'b1, 16'h00AA, aliveSel ? 16'hDCBA : 16'hABCD);
    aliveSel = ~aliveSel;
  endtask
endmodule // supervisory_master_model

// [test/supervisory_link_register_map_tb_top.sv]
// Self-checking bench for the supervisory link register map
module supervisory_link_register_map_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic [8:0]  acceptMask = 9'h1FF;
  logic [31:0] burnerCycles = 32'h000186A0;
  logic [31:0] burnerHours = 32'h000F423F;
  logic [15:0] firingRateIn = 16'h00FA;
  logic [2:0]  errorTypeIn = 3'h7;
  logic [15:0] relayMapIn = 16'h0006;
  wire         regRd, regWr, regAck_r, regExc_r, linkLost, spaceHeatPermit_r, spaceHeatDemand_r;
  wire  [15:0] regAddr, regWrData, regRdData_r, spaceHeatSetpoint_r, headerTemp_r;
  wire         hotWaterPermit_r, hotWaterDemand_r;
  wire  [15:0] hotWaterSetpoint_r, tankSetpoint_r, outdoorTemp_r, loopCurrent_r, hotWaterTemp_r;
  wire  [7:0]  excCode_r;
  int          n_errors = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [15:0] roAddr [6] = '{16'h0097, 16'h0098, 16'h0099, 16'h0087, 16'h008A, 16'h0096};
  always #4 clk = ~clk;
  supervisory_master_model i_master (.clk(clk), .regRd(regRd), .regWr(regWr), .regAddr(regAddr),
    .regWrData(regWrData));
  supervisory_link_register_map #(.TW(32)) i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .regRd(regRd),
    .regWr(regWr), .regAddr(regAddr), .regWrData(regWrData), .regRdData_r(regRdData_r),
    .regAck_r(regAck_r), .regExc_r(regExc_r), .excCode_r(excCode_r), .linkAliveTimeout(32'h00000014),
    .acceptMask(acceptMask), .burnerCycles(burnerCycles), .burnerHours(burnerHours),
    .firingRateIn(firingRateIn), .errorTypeIn(errorTypeIn), .relayMapIn(relayMapIn),
    .linkLost(linkLost), .spaceHeatPermit_r(spaceHeatPermit_r), .spaceHeatDemand_r(spaceHeatDemand_r),
    .spaceHeatSetpoint_r(spaceHeatSetpoint_r), .hotWaterPermit_r(hotWaterPermit_r),
    .hotWaterDemand_r(hotWaterDemand_r), .hotWaterSetpoint_r(hotWaterSetpoint_r),
    .tankSetpoint_r(tankSetpoint_r), .headerTemp_r(headerTemp_r), .outdoorTemp_r(outdoorTemp_r),
    .loopCurrent_r(loopCurrent_r), .hotWaterTemp_r(hotWaterTemp_r));
  // ****************************************
  // Checking tasks
  // ****************************************
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic expect_exc(input logic [7:0] code);
    chk({15'h0000, regExc_r}, {15'h0000, code != 8'h00});
    if (code != 8'h00)
      chk({8'h00, excCode_r}, {8'h00, code});
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [7:0] code);
    i_master.xfer(1'b1, a, d);
    expect_exc(code);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    i_master.xfer(1'b0, a, 16'h0000);
    chk({15'h0000, regAck_r}, 16'h0001);
    chk(regRdData_r, exp);
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      $display("unexpected at %0t: timeout", $time);
      print_verdict();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(16'h00AE, 16'h8100);
    chk({15'h0000, linkLost}, 16'h0001);
    for (int i = 0; i < 6; i++)
      wr(roAddr[i], 16'h0001, 8'h02);
    i_master.xfer(1'b0, 16'h0096, 16'h0000);
    expect_exc(8'h02);
    wr(16'h00AB, 16'h0002, 8'h03);
    wr(16'h00C2, 16'h0005, 8'h03);
    rd(16'h0097, 16'h0001);
    @(posedge clk);
    burnerCycles <= 32'h00020000;
    rd(16'h0098, 16'h86A0);
    rd(16'h0099, 16'h000F);
    rd(16'h009A, 16'h423F);
    rd(16'h0087, 16'h00C8);
    rd(16'h008A, 16'h0004);
    rd(16'h006F, 16'h0006);
    wr(16'h00AE, 16'h02AB, 8'h00);
    rd(16'h00AE, 16'h8100);
    i_master.beat();
    chk({15'h0000, linkLost}, 16'h0000);
    wr(16'h00AE, 16'h02AB, 8'h00);
    rd(16'h00AE, 16'h02AB);
    tick();
    chk(headerTemp_r, 16'h02AB);
    wr(16'h00AF, 16'h0515, 8'h00);
    rd(16'h00AF, 16'h8500);
    wr(16'h00AF, 16'hFE70, 8'h00);
    rd(16'h00AF, 16'hFE70);
    chk(outdoorTemp_r, 16'hFE70);
    i_master.beat();
    wr(16'h00B0, 16'h0027, 8'h00);
    rd(16'h00B0, 16'h8500);
    wr(16'h00B0, 16'h00C8, 8'h00);
    rd(16'h00B0, 16'h00C8);
    chk(loopCurrent_r, 16'h00C8);
    wr(16'h00AE, 16'h8000, 8'h00);
    rd(16'h00AE, 16'h8500);
    i_master.beat();
    wr(16'h00AB, 16'h0000, 8'h00);
    tick();
    chk({15'h0000, spaceHeatPermit_r}, 16'h0000);
    wr(16'h00AB, 16'h0001, 8'h00);
    wr(16'h00AD, 16'h0001, 8'h00);
    tick();
    chk({14'h0000, spaceHeatPermit_r, spaceHeatDemand_r}, 16'h0003);
    wr(16'h00AD, 16'h0000, 8'h00);
    tick();
    chk({15'h0000, spaceHeatDemand_r}, 16'h0000);
    i_master.beat();
    wr(16'h00C3, 16'h0320, 8'h00);
    wr(16'h00C2, 16'h0001, 8'h00);
    wr(16'h00C0, 16'h02BC, 8'h00);
    tick();
    chk(hotWaterTemp_r, 16'h0320);
    chk({14'h0000, hotWaterPermit_r, hotWaterDemand_r}, 16'h0003);
    chk(hotWaterSetpoint_r, 16'h02BC);
    chk(tankSetpoint_r, 16'h8300);
    @(posedge clk);
    acceptMask <= 9'h07E;
    wr(16'h00AC, 16'h031A, 8'h00);
    tick();
    chk(spaceHeatSetpoint_r, 16'h8300);
    chk({14'h0000, hotWaterPermit_r, hotWaterDemand_r}, 16'h0002);
    chk(hotWaterTemp_r, 16'h8100);
    @(posedge clk);
    acceptMask <= 9'h1FF;
    tick();
    tick();
    chk(spaceHeatSetpoint_r, 16'h031A);
    chk(hotWaterTemp_r, 16'h0320);
    repeat (30) @(posedge clk);
    #1;
    chk({15'h0000, linkLost}, 16'h0001);
    chk(headerTemp_r, 16'h8100);
    chk(outdoorTemp_r, 16'h8100);
    chk(loopCurrent_r, 16'h8100);
    chk(hotWaterTemp_r, 16'h8100);
    rd(16'h00B0, 16'h8100);
    i_master.beat();
    chk({15'h0000, linkLost}, 16'h0000);
    rd(16'h00AF, 16'h8100);
    // Write while clock enable is low must not land
    @(posedge clk);
    ce <= 1'b0;
    i_master.xfer(1'b1, 16'h00AE, 16'h0190);
    chk({14'h0000, regAck_r, regExc_r}, 16'h0000);
    @(posedge clk);
    ce <= 1'b1;
    rd(16'h00AE, 16'h8100);
    print_verdict();
  end
endmodule // supervisory_link_register_map_tb_top
